// [inc/ncr_pkg.sv]
`default_nettype none
package ncr_pkg;

   // Message layout, byte offsets within the request buffer
   localparam int unsigned MSG_BYTES   = 16;
   localparam int unsigned OFS_UID     = 2;
   localparam int unsigned OFS_CODE    = 6;
   localparam int unsigned OFS_RETCODE = 7;
   localparam int unsigned OFS_MASK    = 8;
   localparam int unsigned OFS_ARG     = 9;
   localparam int unsigned OFS_DATA    = 10;

   // Request codes
   localparam logic [7:0] REQ_MODE = 8'h08;
   localparam logic [7:0] REQ_ADDR = 8'h09;
   localparam logic [7:0] REQ_RECV = 8'h0a;

   // Return codes
   localparam logic [7:0] RC_OK      = 8'h00;
   localparam logic [7:0] RC_NOT_CTL = 8'ha1;
   localparam logic [7:0] RC_NO_SLOT = 8'hd1;
   localparam logic [7:0] RC_EMPTY   = 8'hd2;
   localparam logic [7:0] RC_BAD_ADR = 8'hd3;
   localparam logic [7:0] RC_BAD_REQ = 8'hff;

   // Request mask bits
   localparam int unsigned MASK_WR  = 0;
   localparam int unsigned MASK_RD  = 1;
   localparam int unsigned MASK_ENA = 2;
   localparam logic [7:0]  REPLY_VALID = 8'h08;
   localparam logic [7:0]  REPLY_RXEN  = 8'h04;

   // Options bits
   localparam int unsigned OPT_ALIGN  = 4;
   localparam int unsigned OPT_CRC    = 5;
   localparam int unsigned OPT_NETDIS = 7;
   localparam logic [7:0]  OPT_MASK   = 8'hb0;

   // Slots
   localparam int unsigned MC_SLOTS   = 8;
   localparam int unsigned SLOT_TOTAL = MC_SLOTS + 2;
   localparam logic [7:0]  SLOT_PHYS  = 8'hfd;
   localparam logic [7:0]  SLOT_BCAST = 8'hff;
   localparam logic [3:0]  IDX_PHYS   = 4'h0;
   localparam logic [3:0]  IDX_BCAST  = 4'h9;
   localparam logic [47:0] ADDR_BCAST = 48'hffff_ffff_ffff;

   // Register byte addresses
   localparam logic [4:0] ADR_MSG0   = 5'h00;
   localparam logic [4:0] ADR_CTRL   = 5'h10;
   localparam logic [4:0] ADR_STATUS = 5'h14;
   localparam logic [4:0] ADR_CONFIG = 5'h18;

   // Field positions and reset values
   localparam int unsigned CTRL_LLC   = 0;
   localparam int unsigned CTRL_GO    = 1;
   localparam int unsigned STAT_BUSY  = 0;
   localparam int unsigned STAT_DONE  = 1;
   localparam logic        LLC_RST    = 1'b1;
   localparam logic [7:0]  LIMIT_RST  = 8'h08;
   localparam logic [1:0]  MODE_RST   = 2'h0;
   localparam logic [7:0]  OPT_RST    = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } ncr_state_e;

endpackage

`default_nettype wire

// [rtl/ncr_top.sv]
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Host zeroes the two reserved bytes; reply leaves them undefined.
// R2: User identifier bytes 2..5 are returned untouched.
// R3: Code 08H is mode/options, 09H address slot; code returned unchanged.
// R4: Byte 7 gets zero on success, 0A1H when not in controller mode.
// R5: Mask 01 write, 02 read, 03 both; other bits zero.
// R6: Mode/options reply leaves the mask byte undefined.
// R7: Options bit 10H accepts frames with alignment errors.
// R8: Options bit 20H accepts frames with failing checksum.
// R9: Options bit 80H keeps the medium quiet while modes still apply.
// R10: Options byte used on write; read returns prior options.
// R11: Mode 0 off, 1 exact multicast, 2 hashed multicast, 3 all frames.
// R12: Mode byte used on write; read returns prior mode.
// R13: Invalid address write is skipped; slot keeps old address.
// R14: Writing a slot address disables reception on that slot.
// R15: Missing or forbidden slot answers 0D1H.
// R16: Wrong address kind or write to slot 255 answers 0D3H.
// R17: Read reply sets mask 8 when slot held a valid address.
// R18: Slot is 253 or multicast 1..limit; slot byte returned unchanged. Code also accepts slot 255 and caps limit at 8.
// R19: Read of occupied slot returns its prior address at offset 10.
// R20: Code 0AH with mask and slot reads or changes slot reception.
// R21: On write, mask bit 04 enables, else disables slot reception.
// R22: Read sets mask 4 if reception was on; empty slot answers 0D2H.
// R23: Prior values are captured before new settings are applied.
// R24: Replies return in the same buffer, in arrival order.
module ncr_top
   import ncr_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     rst_n_i,
   // Avalon-MM slave
   input  wire logic [4:0]               address_i,
   input  wire logic                     read_i,
   input  wire logic                     write_i,
   input  wire logic [3:0]               byteenable_i,
   input  wire logic [31:0]              writedata_i,
   output logic      [31:0]              readdata_o,
   output logic                          waitrequest_o,
   // Receive controller settings
   output logic      [1:0]               mode_o,
   output logic                          medium_en_o,
   output logic                          accept_align_err_o,
   output logic                          accept_crc_err_o,
   output logic      [47:0]              phys_addr_o,
   output logic      [ncr_pkg::SLOT_TOTAL-1:0] slot_rx_en_o,
   output logic      [ncr_pkg::SLOT_TOTAL-1:0] slot_valid_o
);

   // Bus handshake: every access waits exactly one cycle
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic        acc_take;
   logic        acc_wr;

   assign acc_take = (read_i | write_i) & ~wait_q;
   assign acc_wr   = write_i & ~wait_q;

   // Engine state
   ncr_state_e  state_q, state_d;
   logic [7:0]  msg_q [MSG_BYTES];
   logic [7:0]  msg_d [MSG_BYTES];
   logic [1:0]  mode_q, mode_d;
   logic [7:0]  opt_q, opt_d;
   logic        llc_q, llc_d;
   logic        done_q, done_d;
   logic [7:0]  limit_q, limit_d;
   logic [47:0] addr_q [SLOT_TOTAL];
   logic [47:0] addr_d [SLOT_TOTAL];
   logic [SLOT_TOTAL-1:0] valid_q, valid_d;
   logic [SLOT_TOTAL-1:0] rxen_q, rxen_d;
   logic        medium_q, medium_d;

   // Maps a slot number onto the storage index; bit 4 flags existence
   function automatic logic [4:0] slot_decode(input logic [7:0] slot, input logic [7:0] limit);
      logic [7:0] lim;
      lim = (limit > 8'(MC_SLOTS)) ? 8'(MC_SLOTS) : limit;
      if (slot == SLOT_PHYS)
         slot_decode = {1'b1, IDX_PHYS};
      else if (slot == SLOT_BCAST)
         slot_decode = {1'b1, IDX_BCAST};
      else if (slot != 8'h00 && slot <= lim)
         slot_decode = {1'b1, slot[3:0]};
      else
         slot_decode = 5'h00;
   endfunction

   // Bus group
   always_comb begin
      wait_d  = ~((read_i | write_i) & wait_q);
      rdata_d = rdata_q;
      if (read_i & wait_q) begin
         rdata_d = 32'h0000_0000;
         if (address_i[4] == 1'b0)
            rdata_d = {msg_q[{address_i[3:2], 2'h3}], msg_q[{address_i[3:2], 2'h2}],
                       msg_q[{address_i[3:2], 2'h1}], msg_q[{address_i[3:2], 2'h0}]};
         else if (address_i == ADR_CTRL)
            rdata_d[CTRL_LLC] = llc_q;
         else if (address_i == ADR_STATUS) begin
            rdata_d[STAT_BUSY] = (state_q == ST_EXEC);
            rdata_d[STAT_DONE] = done_q;
         end else if (address_i == ADR_CONFIG)
            rdata_d[7:0] = limit_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign waitrequest_o = wait_q;
   assign readdata_o    = rdata_q;

   // Engine group
   logic [7:0]  e_code;
   logic [7:0]  e_mask;
   logic [7:0]  e_slot;
   logic [47:0] e_addr;
   logic [4:0]  e_dec;
   logic [3:0]  e_idx;
   logic [7:0]  e_rc;

   always_comb begin
      state_d = state_q;
      msg_d   = msg_q;
      mode_d  = mode_q;
      opt_d   = opt_q;
      llc_d   = llc_q;
      done_d  = done_q;
      limit_d = limit_q;
      addr_d  = addr_q;
      valid_d = valid_q;
      rxen_d  = rxen_q;
      e_code  = msg_q[OFS_CODE];
      e_mask  = msg_q[OFS_MASK];
      e_slot  = msg_q[OFS_ARG];
      e_addr  = {msg_q[OFS_DATA], msg_q[OFS_DATA+1], msg_q[OFS_DATA+2],
                 msg_q[OFS_DATA+3], msg_q[OFS_DATA+4], msg_q[OFS_DATA+5]};
      e_dec   = slot_decode(e_slot, limit_q);
      e_idx   = e_dec[3:0];
      e_rc    = RC_OK;

      // Software side; the buffer is frozen while a request executes
      if (acc_wr) begin
         if (address_i[4] == 1'b0 && state_q == ST_IDLE) begin
            for (int b = 0; b < 4; b++) begin
               if (byteenable_i[b])
                  msg_d[{address_i[3:2], 2'(b)}] = writedata_i[8*b +: 8];
            end
         end else if (address_i == ADR_CTRL && byteenable_i[0]) begin
            llc_d = writedata_i[CTRL_LLC];
            if (writedata_i[CTRL_GO] && state_q == ST_IDLE)
               state_d = ST_EXEC;
         end else if (address_i == ADR_STATUS && byteenable_i[0] && writedata_i[STAT_DONE])
            done_d = 1'b0;
         else if (address_i == ADR_CONFIG && byteenable_i[0])
            limit_d = writedata_i[7:0];
      end

      case (state_q)
         ST_IDLE: begin
         end
         ST_EXEC: begin
            // Reply fields read the _q copies, so prior values win over new ones R23
            if (!llc_q)
               e_rc = RC_NOT_CTL; // R4
            else begin
               case (e_code)
                  REQ_MODE: begin // R6
                     if (e_mask[MASK_RD]) begin
                        msg_d[OFS_ARG]  = opt_q; // R10
                        msg_d[OFS_DATA] = {6'h00, mode_q}; // R12
                     end
                     if (e_mask[MASK_WR]) begin
                        opt_d  = msg_q[OFS_ARG] & OPT_MASK;
                        mode_d = msg_q[OFS_DATA][1:0]; // R11
                     end
                  end
                  REQ_ADDR: begin
                     if (!e_dec[4])
                        e_rc = RC_NO_SLOT; // R15
                     else begin
                        if (e_mask[MASK_RD]) begin
                           msg_d[OFS_MASK] = valid_q[e_idx] ? REPLY_VALID : 8'h00; // R17
                           if (valid_q[e_idx]) begin
                              for (int b = 0; b < 6; b++)
                                 msg_d[OFS_DATA+b] = addr_q[e_idx][8*(5-b) +: 8]; // R19
                           end
                        end
                        if (e_mask[MASK_WR]) begin
                           // Group bit is the low bit of the first address byte
                           if (e_idx == IDX_BCAST || ((e_idx == IDX_PHYS) == e_addr[40]))
                              e_rc = RC_BAD_ADR; // R16 R13
                           else begin
                              addr_d[e_idx]  = e_addr;
                              valid_d[e_idx] = 1'b1;
                              rxen_d[e_idx]  = 1'b0; // R14
                           end
                        end
                     end
                  end
                  REQ_RECV: begin
                     if (!e_dec[4])
                        e_rc = RC_NO_SLOT; // R20
                     else if (!valid_q[e_idx])
                        e_rc = RC_EMPTY; // R22
                     else begin
                        if (e_mask[MASK_RD])
                           msg_d[OFS_MASK] = rxen_q[e_idx] ? REPLY_RXEN : 8'h00; // R22
                        if (e_mask[MASK_WR])
                           rxen_d[e_idx] = e_mask[MASK_ENA]; // R21
                     end
                  end
                  default: e_rc = RC_BAD_REQ;
               endcase
            end
            // Identifier, code and slot bytes are never rewritten R2 R3 R18
            msg_d[OFS_RETCODE] = e_rc;
            done_d  = 1'b1; // R24
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
      // Medium runs only when connected and not net-disabled
      medium_d = (mode_d != 2'h0) && !opt_d[OPT_NETDIS]; // R9
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q  <= ST_IDLE;
         mode_q   <= MODE_RST;
         opt_q    <= OPT_RST;
         llc_q    <= LLC_RST;
         done_q   <= 1'b0;
         limit_q  <= LIMIT_RST;
         valid_q  <= SLOT_TOTAL'(1) << IDX_BCAST;
         rxen_q   <= '0;
         medium_q <= 1'b0;
         for (int i = 0; i < MSG_BYTES; i++)
            msg_q[i] <= 8'h00;
         for (int i = 0; i < SLOT_TOTAL; i++)
            addr_q[i] <= (i == int'(IDX_BCAST)) ? ADDR_BCAST : 48'h0000_0000_0000;
      end else begin
         state_q  <= state_d;
         mode_q   <= mode_d;
         opt_q    <= opt_d;
         llc_q    <= llc_d;
         done_q   <= done_d;
         limit_q  <= limit_d;
         valid_q  <= valid_d;
         rxen_q   <= rxen_d;
         medium_q <= medium_d;
         msg_q    <= msg_d;
         addr_q   <= addr_d;
      end
   end

   assign mode_o             = mode_q; // R11
   assign medium_en_o        = medium_q;
   assign accept_align_err_o = opt_q[OPT_ALIGN]; // R7
   assign accept_crc_err_o   = opt_q[OPT_CRC]; // R8
   assign phys_addr_o        = addr_q[IDX_PHYS];
   assign slot_rx_en_o       = rxen_q;
   assign slot_valid_o       = valid_q;

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   logic go_wr;
   assign go_wr = acc_wr && address_i == ADR_CTRL && byteenable_i[0]
                  && writedata_i[CTRL_GO] && state_q == ST_IDLE;
   logic exec_ok;
   assign exec_ok = state_q == ST_EXEC && llc_q;
   logic addr_ok;
   assign addr_ok = exec_ok && e_code == REQ_ADDR && e_dec[4];
   logic recv_ok;
   assign recv_ok = exec_ok && e_code == REQ_RECV && e_dec[4] && valid_q[e_idx];
   logic recv_ena;
   assign recv_ena = e_mask[MASK_ENA];
   logic [47:0] slot_addr;
   assign slot_addr = addr_q[e_idx];
   logic [1:0] mode_wr;
   assign mode_wr = msg_q[OFS_DATA][1:0];
   logic align_wr;
   assign align_wr = msg_q[OFS_ARG][OPT_ALIGN];
   logic crc_wr;
   assign crc_wr = msg_q[OFS_ARG][OPT_CRC];

   sequence s_submit;
      go_wr;
   endsequence
   sequence s_reply;
      state_q == ST_EXEC ##1 (state_q == ST_IDLE && done_q);
   endsequence

   a_reply_after_go: assert property (s_submit |=> s_reply) // R24
      else $error("reply not posted one cycle after submit");
   a_uid_kept: assert property (state_q == ST_EXEC |=> // R2
      {msg_q[2], msg_q[3], msg_q[4], msg_q[5]} == $past({msg_q[2], msg_q[3], msg_q[4], msg_q[5]}))
      else $error("user identifier altered");
   a_code_kept: assert property (state_q == ST_EXEC |=> msg_q[OFS_CODE] == $past(msg_q[OFS_CODE])) // R3
      else $error("request code altered");
   a_not_ctl_code: assert property (state_q == ST_EXEC && !llc_q |=> msg_q[OFS_RETCODE] == RC_NOT_CTL) // R4
      else $error("missing controller mode code");
   a_opt_read_prior: assert property (exec_ok && e_code == REQ_MODE && e_mask[MASK_RD] // R10
      |=> msg_q[OFS_ARG] == $past(opt_q))
      else $error("options read not prior value");
   a_mode_read_prior: assert property (exec_ok && e_code == REQ_MODE && e_mask[MASK_RD] // R12
      |=> msg_q[OFS_DATA] == {6'h00, $past(mode_q)})
      else $error("mode read not prior value");
   a_bcast_write_err: assert property (exec_ok && e_code == REQ_ADDR && e_slot == SLOT_BCAST // R16
      && e_mask[MASK_WR] |=> msg_q[OFS_RETCODE] == RC_BAD_ADR)
      else $error("broadcast slot write not refused");
   a_phys_write_off: assert property (exec_ok && e_code == REQ_ADDR && e_slot == SLOT_PHYS // R14
      && e_mask[MASK_WR] && !e_addr[40] |=> !slot_rx_en_o[IDX_PHYS] ##1 !slot_rx_en_o[IDX_PHYS])
      else $error("address write left reception on");
   a_netdis_quiet: assert property (opt_q[OPT_NETDIS] |-> !medium_en_o) // R9
      else $error("medium active while net disabled");
   a_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("request not answered after one wait cycle");
   a_wait_single: assert property (acc_take |=> waitrequest_o)
      else $error("wait released for more than one cycle");
   a_bad_slot_code: assert property (exec_ok && (e_code == REQ_ADDR || e_code == REQ_RECV) && !e_dec[4] // R15
      |=> msg_q[OFS_RETCODE] == RC_NO_SLOT)
      else $error("missing slot not refused");
   a_empty_slot_code: assert property (exec_ok && e_code == REQ_RECV && e_dec[4] && !valid_q[e_idx] // R22
      |=> msg_q[OFS_RETCODE] == RC_EMPTY)
      else $error("empty slot not reported");
   a_valid_flag_set: assert property (addr_ok && e_mask[MASK_RD] && valid_q[e_idx] // R17
      |=> msg_q[OFS_MASK] == REPLY_VALID)
      else $error("occupied slot not flagged");
   a_empty_flag_clr: assert property (addr_ok && e_mask[MASK_RD] && !valid_q[e_idx] // R17
      |=> msg_q[OFS_MASK] == 8'h00)
      else $error("empty slot flagged as occupied");
   a_rxen_flag_set: assert property (recv_ok && e_mask[MASK_RD] && rxen_q[e_idx] // R22
      |=> msg_q[OFS_MASK] == REPLY_RXEN)
      else $error("enabled slot not flagged");
   a_rxen_flag_clr: assert property (recv_ok && e_mask[MASK_RD] && !rxen_q[e_idx] // R22
      |=> msg_q[OFS_MASK] == 8'h00)
      else $error("disabled slot flagged as enabled");
   a_rxen_write_apply: assert property (recv_ok && e_mask[MASK_WR] // R21
      |=> slot_rx_en_o[$past(e_idx)] == $past(recv_ena))
      else $error("reception enable not applied");
   a_phys_group_reject: assert property (exec_ok && e_code == REQ_ADDR && e_slot == SLOT_PHYS // R13
      && e_mask[MASK_WR] && e_addr[40] |=> $stable(phys_addr_o) && msg_q[OFS_RETCODE] == RC_BAD_ADR)
      else $error("group address stored in physical slot");
   a_mc_phys_reject: assert property (addr_ok && e_slot != SLOT_PHYS && e_slot != SLOT_BCAST // R16
      && e_mask[MASK_WR] && !e_addr[40] |=> msg_q[OFS_RETCODE] == RC_BAD_ADR)
      else $error("physical address accepted by multicast slot");
   a_phys_write_store: assert property (exec_ok && e_code == REQ_ADDR && e_slot == SLOT_PHYS // R14
      && e_mask[MASK_WR] && !e_addr[40] |=> phys_addr_o == $past(e_addr) && slot_valid_o[IDX_PHYS])
      else $error("physical address write lost");
   a_slot_kept: assert property (exec_ok && (e_code == REQ_ADDR || e_code == REQ_RECV) // R18
      |=> msg_q[OFS_ARG] == $past(e_slot))
      else $error("slot number altered");
   a_addr_read_prior: assert property (addr_ok && e_mask[MASK_RD] && valid_q[e_idx] |=> // R19 R23
      {msg_q[OFS_DATA], msg_q[OFS_DATA+1], msg_q[OFS_DATA+2], msg_q[OFS_DATA+3], msg_q[OFS_DATA+4],
       msg_q[OFS_DATA+5]} == $past(slot_addr))
      else $error("prior slot address not returned");
   a_mode_write_apply: assert property (exec_ok && e_code == REQ_MODE && e_mask[MASK_WR] // R11
      |=> mode_o == $past(mode_wr))
      else $error("mode write not applied");
   a_align_opt_write: assert property (exec_ok && e_code == REQ_MODE && e_mask[MASK_WR] // R7
      |=> accept_align_err_o == $past(align_wr))
      else $error("alignment option not applied");
   a_crc_opt_write: assert property (exec_ok && e_code == REQ_MODE && e_mask[MASK_WR] // R8
      |=> accept_crc_err_o == $past(crc_wr))
      else $error("checksum option not applied");
   a_mask_kept_mode: assert property (exec_ok && e_code == REQ_MODE |=> msg_q[OFS_MASK] == $past(e_mask)) // R6
      else $error("mode request mask byte rewritten");
   a_not_ctl_hold: assert property (state_q == ST_EXEC && !llc_q // R4
      |=> $stable(mode_o) && $stable(slot_rx_en_o) && $stable(slot_valid_o))
      else $error("settings changed outside controller mode");

endmodule

`default_nettype wire

// [sim/ncr_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host software stand-in: fills the shared message, submits it, collects the reply
module ncr_host
   import ncr_pkg::*;
(
   // Clock
   input  wire logic        mclk_i,
   // Avalon-MM master
   output logic      [4:0]  address_o,
   output logic             read_o,
   output logic             write_o,
   output logic      [3:0]  byteenable_o,
   output logic      [31:0] writedata_o,
   input  wire logic [31:0] readdata_i,
   input  wire logic        waitrequest_i
);
   logic        llc = 1'b1;
   logic [31:0] uid = 32'h0;

   initial begin
      address_o    = 5'h00;
      read_o       = 1'b0;
      write_o      = 1'b0;
      byteenable_o = 4'hf;
      writedata_o  = 32'h0;
   end

   // One idle edge after release, so a following request never lands in the release time step
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
      address_o   <= a;
      writedata_o <= wd;
      write_o     <= wr;
      read_o      <= ~wr;
      do begin
         @(posedge mclk_i);
      end while (waitrequest_i !== 1'b0);
      rd = readdata_i;
      write_o <= 1'b0;
      read_o  <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic req(input logic [7:0] c, input logic [7:0] m, input logic [7:0] a,
                      input logic [47:0] d, output logic [127:0] rep);
      logic [127:0] msg;
      logic [31:0]  rd;
      msg         = 128'h0;
      uid         = uid + 32'h0101_0101;
      msg[16+:32] = uid;
      msg[48+:8]  = c;
      msg[64+:8]  = m;
      msg[72+:8]  = a;
      for (int i = 0; i < 6; i++) begin
         msg[80+8*i+:8] = d[47-8*i-:8];
      end
      for (int w = 0; w < 4; w++) begin
         bus(1'b1, 5'(4*w), msg[32*w+:32], rd);
      end
      bus(1'b1, ADR_CTRL, {30'h0, 1'b1, llc}, rd);
      do begin
         bus(1'b0, ADR_STATUS, 32'h0, rd);
      end while (rd[STAT_DONE] !== 1'b1);
      for (int w = 0; w < 4; w++) begin
         bus(1'b0, 5'(4*w), 32'h0, rd);
         rep[32*w+:32] = rd;
      end
      bus(1'b1, ADR_STATUS, 32'h2, rd);
   endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
   import ncr_pkg::*;
;
   typedef struct packed {
      logic [7:0]  c, m, a;
      logic [47:0] d;
      logic [7:0]  rc, e8, e9;
      logic [47:0] ed;
      logic [2:0]  ck;
   } ncr_row_s;
   localparam int NROWS = 19;
   // ck: bit0 mask byte, bit1 slot/options byte, bit2 data field
   ncr_row_s rows [NROWS] = '{
      '{8'h08,8'h03,8'hb0,48'h0300_0000_0000,8'h00,8'h03,8'h00,48'h0,3'b111},
      '{8'h08,8'h02,8'h00,48'h0,8'h00,8'h00,8'hb0,48'h0300_0000_0000,3'b110},
      '{8'h08,8'h01,8'h30,48'h0200_0000_0000,8'h00,8'h00,8'h00,48'h0,3'b000},
      '{8'h09,8'h03,8'hfd,48'h0211_2233_4455,8'h00,8'h00,8'hfd,48'h0,3'b011},
      '{8'h09,8'h02,8'hfd,48'h0,8'h00,8'h08,8'hfd,48'h0211_2233_4455,3'b111},
      '{8'h09,8'h01,8'hfd,48'h0111_2233_4455,8'hd3,8'h00,8'hfd,48'h0,3'b010},
      '{8'h09,8'h01,8'hff,48'h0100_0000_0001,8'hd3,8'h00,8'hff,48'h0,3'b010},
      '{8'h09,8'h01,8'h01,48'h0200_0000_0000,8'hd3,8'h00,8'h01,48'h0,3'b010},
      '{8'h09,8'h02,8'hfd,48'h0,8'h00,8'h08,8'hfd,48'h0211_2233_4455,3'b111},
      '{8'h09,8'h02,8'h09,48'h0,8'hd1,8'h00,8'h09,48'h0,3'b010},
      '{8'h09,8'h02,8'h00,48'h0,8'hd1,8'h00,8'h00,48'h0,3'b010},
      '{8'h0a,8'h02,8'h02,48'h0,8'hd2,8'h00,8'h02,48'h0,3'b010},
      '{8'h0a,8'h05,8'hfd,48'h0,8'h00,8'h00,8'hfd,48'h0,3'b010},
      '{8'h0a,8'h02,8'hfd,48'h0,8'h00,8'h04,8'hfd,48'h0,3'b011},
      '{8'h09,8'h01,8'hfd,48'h0a1b_2c3d_4e5f,8'h00,8'h00,8'hfd,48'h0,3'b010},
      '{8'h0a,8'h02,8'hfd,48'h0,8'h00,8'h00,8'hfd,48'h0,3'b011},
      '{8'h09,8'h03,8'h08,48'h0333_4455_6677,8'h00,8'h00,8'h08,48'h0,3'b011},
      '{8'h0a,8'h07,8'h08,48'h0,8'h00,8'h00,8'h08,48'h0,3'b011},
      '{8'h0a,8'h02,8'h08,48'h0,8'h00,8'h04,8'h08,48'h0,3'b011}
   };

   logic                  mclk_i, rst_n_i, read, write, waitrequest, medium_en, align_ok, crc_ok;
   logic [4:0]            address;
   logic [3:0]            byteenable;
   logic [31:0]           writedata, readdata, rd;
   logic [1:0]            mode;
   logic [47:0]           phys_addr;
   logic [SLOT_TOTAL-1:0] rx_en, slot_vld;
   logic [127:0]          rep;
   int                    fail_count = 0;
   int                    checks = 0;
   int                    cyc = 0;

   ncr_top i_dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_i(address), .read_i(read), .write_i(write),
      .byteenable_i(byteenable), .writedata_i(writedata), .readdata_o(readdata), .waitrequest_o(waitrequest),
      .mode_o(mode), .medium_en_o(medium_en), .accept_align_err_o(align_ok), .accept_crc_err_o(crc_ok),
      .phys_addr_o(phys_addr), .slot_rx_en_o(rx_en), .slot_valid_o(slot_vld)
   );
   ncr_host i_host (
      .mclk_i(mclk_i), .address_o(address), .read_o(read), .write_o(write), .byteenable_o(byteenable),
      .writedata_o(writedata), .readdata_i(readdata), .waitrequest_i(waitrequest)
   );

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [47:0] dat(input logic [127:0] r);
      for (int i = 0; i < 6; i++) begin
         dat[47-8*i-:8] = r[80+8*i+:8];
      end
   endfunction

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      check(48'({mode, medium_en, align_ok, crc_ok}), 48'h0);
      check(48'({rx_en, slot_vld}), 48'h200);
      check(phys_addr, 48'h0);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      i_host.bus(1'b0, ADR_CTRL, 32'h0, rd);
      check(48'(rd), 48'h1);
      i_host.bus(1'b0, ADR_CONFIG, 32'h0, rd);
      check(48'(rd), 48'h8);
      i_host.bus(1'b0, ADR_STATUS, 32'h0, rd);
      check(48'(rd), 48'h0);
      $display("reset test done");
   endtask

   // A hang anywhere counts as a mismatch
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      do_reset();
      for (int i = 0; i < NROWS; i++) begin
         i_host.req(rows[i].c, rows[i].m, rows[i].a, rows[i].d, rep);
         check(48'(rep[56+:8]), 48'(rows[i].rc));
         check(48'(rep[48+:8]), 48'(rows[i].c));
         check(48'(rep[16+:32]), 48'(i_host.uid));
         if (rows[i].ck[0]) begin
            check(48'(rep[64+:8]), 48'(rows[i].e8));
         end
         if (rows[i].ck[1]) begin
            check(48'(rep[72+:8]), 48'(rows[i].e9));
         end
         if (rows[i].ck[2]) begin
            check(dat(rep), rows[i].ed);
         end
         $display("row %0d done", i);
      end
      check(48'({mode, medium_en, align_ok, crc_ok}), 48'h17);
      check(48'({rx_en, slot_vld}), 48'h40301);
      check(phys_addr, 48'h0a1b_2c3d_4e5f);
      i_host.req(REQ_MODE, 8'h01, 8'h80, 48'h0300_0000_0000, rep);
      check(48'({mode, medium_en, align_ok, crc_ok}), 48'h18);
      i_host.req(8'h0b, 8'h02, 8'h00, 48'h0, rep);
      check(48'(rep[56+:8]), 48'(RC_BAD_REQ));
      i_host.bus(1'b1, ADR_CONFIG, 32'h2, rd);
      i_host.req(REQ_ADDR, 8'h02, 8'h03, 48'h0, rep);
      check(48'(rep[56+:8]), 48'(RC_NO_SLOT));
      i_host.llc = 1'b0;
      i_host.req(REQ_MODE, 8'h03, 8'h00, 48'h0, rep);
      check(48'(rep[56+:8]), 48'(RC_NOT_CTL));
      check(48'(mode), 48'h3);
      i_host.llc = 1'b1;
      i_host.bus(1'b1, 5'h1c, 32'h1234_5678, rd);
      i_host.bus(1'b0, 5'h1c, 32'h0, rd);
      check(48'(rd), 48'h0);
      $display("hand tests done");
      do_reset();
      finish_test();
   end
endmodule
`default_nettype wire
